// file: bench/output_status_flag_registers_asserts.sv
`timescale 1ns/1ps
// Port-level checks for the status and flag registers
module osf_port_checker
   import osf_pkg::*;
#(
   parameter int STEP_CYC = 2
) (
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   rst_b,
   // Observed ports
   input wire osf_pkg::reg_req_t      req,
   input wire logic [7:0]             rdata_r,
   input wire osf_pkg::power_status_t pwr_in,
   input wire osf_pkg::event_status_t evt_in,
   input wire osf_pkg::line_ctrl_t    line_ctrl
);
   logic [2:0] up_cnt; // Edges since reset, saturating

   // Status reads judged only once the synchronisers hold real samples
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h7)
         up_cnt <= up_cnt + 3'h1;
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_unmute_write: assert property (
      req.wr && req.addr == 8'h5D |=> line_ctrl.unmute == $past(req.wdata[3]))
      else $error("unmute does not follow written bit");
   a_mute_release: assert property (
      $rose(rst_b) |-> line_ctrl.unmute == 1'b0 && line_ctrl.gain == 4'h0)
      else $error("line stage not muted at reset release");
   a_gain_one_step: assert property (
      $changed(line_ctrl.gain) |-> 4'(line_ctrl.gain - $past(line_ctrl.gain)) inside {4'h1, 4'hF})
      else $error("gain moved more than one step");
   a_power_read: assert property (
      req.rd && req.addr == 8'h5E && up_cnt == 3'h7 && $stable(pwr_in) && pwr_in == $past(pwr_in, 2)
      |=> rdata_r == {$past(pwr_in[7:6]), 1'b0, $past(pwr_in[5:2]), 1'b0})
      else $error("power status read wrong");
   a_short_read: assert property (
      req.rd && req.addr == 8'h5F && up_cnt == 3'h7 && $stable(pwr_in) && $stable(evt_in)
      && pwr_in == $past(pwr_in, 2) && evt_in == $past(evt_in, 2)
      |=> rdata_r == {$past(evt_in[6:3]), $past(pwr_in[1:0]), 2'b00})
      else $error("short status read wrong");
   a_line_power: assert property (
      req.rd && req.addr == 8'h5D && up_cnt == 3'h7 && $stable(pwr_in) && pwr_in == $past(pwr_in, 2)
      |=> rdata_r[0] == $past(pwr_in.line_r) && rdata_r[2] == 1'b0)
      else $error("line output power bit wrong");
   a_sticky_set: assert property (
      req.rd && req.addr == 8'h60 && up_cnt == 3'h7
      |=> (rdata_r | ~{$past(evt_in[6:3], 4), 2'b00, $past(evt_in[1:0], 4)}) == 8'hFF)
      else $error("sticky flag missed an event");
   a_read_clears: assert property (
      (req.rd && req.addr == 8'h60 && up_cnt == 3'h7 && evt_in == '0 && $past(evt_in) == '0
      && $past(evt_in, 2) == '0 && $past(evt_in, 3) == '0) ##2 (req.rd && req.addr == 8'h60)
      |=> rdata_r == 8'h00)
      else $error("sticky flags survived a read");
   a_unmapped_zero: assert property (
      req.rd && !(req.addr inside {[8'h5D:8'h61]}) |=> rdata_r == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind output_status_flag_registers osf_port_checker #(.STEP_CYC(STEP_CYC)) u_chk (
   .clock(clock), .rst_b(rst_b), .req(req), .rdata_r(rdata_r),
   .pwr_in(pwr_in), .evt_in(evt_in), .line_ctrl(line_ctrl));

// file: bench/test_output_status_flag_registers.sv
`timescale 1ns/1ps
// Self-checking bench for the status and flag registers
module test_output_status_flag_registers;
   import osf_pkg::*;
   // Table row: status inputs, register read, value expected
   typedef struct packed {
      logic [7:0] pwr;
      logic [6:0] evt;
      logic [7:0] addr;
      logic [7:0] exp;
   } row_t;

   logic          clock;
   logic          rst_b;
   reg_req_t      req;
   logic [7:0]    rdata_r;
   power_status_t pwr_in;
   event_status_t evt_in;
   line_ctrl_t    line_ctrl;
   int            n_fail;
   int            samples_checked;
   int            cycles = 0;   // Owned by the hang guard alone
   logic [7:0]    got;
   logic [3:0]    code;
   row_t          rows [13];

   // Short ramp step keeps the gain walks brief
   output_status_flag_registers #(.STEP_CYC(2)) u_dut (
      .clock(clock), .rst_b(rst_b), .req(req), .rdata_r(rdata_r),
      .pwr_in(pwr_in), .evt_in(evt_in), .line_ctrl(line_ctrl));

   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Hang guard, well above the expected run length
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask

   // Read data is settled by the following falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clock);
      req.rd <= 1'b0;
      @(negedge clock);
      d = rdata_r;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a, got);
      check(got, e);
   endtask

   // One-cycle event, then time for synchroniser and latch
   task automatic pulse(input logic [6:0] e);
      @(posedge clock);
      evt_in <= e;
      @(posedge clock);
      evt_in <= '0;
      repeat (4) @(posedge clock);
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      req = '0;
      pwr_in = '0;
      evt_in = '0;
      n_fail = 0;
      samples_checked = 0;
      rows = '{'{8'h80, 7'h00, 8'h5E, 8'h80}, '{8'h40, 7'h00, 8'h5E, 8'h40},
               '{8'h20, 7'h00, 8'h5E, 8'h10}, '{8'h10, 7'h00, 8'h5E, 8'h08},
               '{8'h10, 7'h00, 8'h5D, 8'h01}, '{8'h08, 7'h00, 8'h5E, 8'h04},
               '{8'h04, 7'h00, 8'h5E, 8'h02}, '{8'h02, 7'h00, 8'h5F, 8'h08},
               '{8'h01, 7'h00, 8'h5F, 8'h04}, '{8'hFF, 7'h00, 8'h5E, 8'hDE},
               '{8'h00, 7'h40, 8'h5F, 8'h80}, '{8'h00, 7'h08, 8'h5F, 8'h10},
               '{8'h00, 7'h02, 8'h61, 8'h02}};
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      // Hold status past the synchroniser, then read
      foreach (rows[i]) begin
         @(posedge clock);
         pwr_in <= rows[i].pwr;
         evt_in <= rows[i].evt;
         repeat (3) @(posedge clock);
         rdc(rows[i].addr, rows[i].exp);
      end
      pulse(7'h00);
      rd(8'h60, got);
      rdc(8'h60, 8'h00);
      pulse(7'h52);
      rdc(8'h60, 8'hA2);
      rdc(8'h60, 8'h00);
      pulse(7'h29);
      rdc(8'h60, 8'h51);
      // Headset insertion and removal each flag once
      @(posedge clock);
      evt_in <= 7'h04;
      repeat (4) @(posedge clock);
      rdc(8'h60, 8'h04);
      rdc(8'h60, 8'h00);
      pulse(7'h00);
      rdc(8'h60, 8'h04);
      // Writing zero clears the right gate flag, writing one keeps it
      pulse(7'h01);
      wr(8'h60, 8'h00);
      rdc(8'h60, 8'h00);
      pulse(7'h01);
      wr(8'h60, 8'h01);
      rdc(8'h60, 8'h01);
      // Read-only registers ignore writes; unmapped reads give zero
      wr(8'h5E, 8'hDE);
      wr(8'h5F, 8'hFC);
      wr(8'h61, 8'hFF);
      rdc(8'h5E, 8'h00);
      rdc(8'h5F, 8'h00);
      rdc(8'h70, 8'h00);
      // Every level code, ramps up and down, mute toggling
      for (int i = 0; i < 10; i++) begin
         code = 4'((i * 7) % 10);
         wr(8'h5D, {code, i[0], 2'b00, i[0]});
         rd(8'h5D, got);
         // First code equals the gain already applied, so nothing pends
         check({7'h00, got[1]}, {7'h00, (i != 0)});
         check({7'h00, line_ctrl.unmute}, {7'h00, i[0]});
         for (int n = 0; n < 40 && line_ctrl.gain !== code; n++)
            @(negedge clock);
         repeat (2) @(negedge clock);
         check({4'h0, line_ctrl.gain}, {4'h0, code});
         rdc(8'h5D, {code, i[0], 3'b000});
      end
      // Mid-run reset returns the stage to muted, zero gain
      @(posedge clock);
      rst_b <= 1'b0;
      @(negedge clock);
      check({3'h0, line_ctrl}, 8'h00);
      check(rdata_r, 8'h00);
      @(posedge clock);
      rst_b <= 1'b1;
      rdc(8'h5D, 8'h00);
      summarize();
   end
endmodule

// file: hdl/level_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser, one chain per bit
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Levels from outside and their safe copies
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("level_sync width must be at least one");
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_r;   // First stage, read only by the second

         // Two flops in a row per bit
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               meta_r      <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_r      <= async_in[i];
               sync_out[i] <= meta_r;
            end
         end
      end
   endgenerate

endmodule

// file: hdl/osf_params.svh
`ifndef OSF_PARAMS_SVH
`define OSF_PARAMS_SVH

// Register byte offsets on the control port
`define OSF_ADDR_LINE_CTRL   8'h5D
`define OSF_ADDR_PWR_STAT    8'h5E
`define OSF_ADDR_SHORT_STAT  8'h5F
`define OSF_ADDR_STICKY      8'h60
`define OSF_ADDR_REALTIME    8'h61

// Line output control field positions
`define OSF_LEVEL_MSB        7
`define OSF_LEVEL_LSB        4
`define OSF_MUTE_BIT         3
`define OSF_PEND_BIT         1
`define OSF_LPWR_BIT         0

// Sticky register bit used for the writable noise gate flag
`define OSF_GATE_R_BIT       0

// Reset values, level limit and unmapped read data
`define OSF_LEVEL_RST        4'h0
`define OSF_MUTE_RST         1'b0
`define OSF_PEND_RST         1'b1
`define OSF_LEVEL_MAX        4'h9
`define OSF_UNMAPPED_DATA    8'h00

// Timing: one gain step per settle interval
`define OSF_CLK_PERIOD_NS    50
`define OSF_GAIN_STEP_NS     1000
`define OSF_GAIN_STEP_CYC    (`OSF_GAIN_STEP_NS / `OSF_CLK_PERIOD_NS)

`endif

// file: hdl/osf_pkg.sv
package osf_pkg;

   // Power-up status lines from the analog modules
   typedef struct packed {
      logic dac_l;
      logic dac_r;
      logic line_l;
      logic line_r;
      logic hp_l;
      logic hp_r;
      logic com_l;
      logic com_r;
   } power_status_t;

   // Live event conditions from the analog side
   typedef struct packed {
      logic [3:0] shorted;   // hp_l, hp_r, com_l, com_r
      logic       headset;   // Headset present level
      logic       gate_l;    // Left signal under noise threshold
      logic       gate_r;    // Right signal under noise threshold
   } event_status_t;

   // Control port request
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_req_t;

   // Settings driven to the right line output stage
   typedef struct packed {
      logic [3:0] gain;
      logic       unmute;
   } line_ctrl_t;

endpackage

// file: hdl/output_status_flag_registers.sv
`timescale 1ns/1ps
`include "osf_params.svh"
module output_status_flag_registers
   import osf_pkg::*;
#(
   parameter int STEP_CYC = `OSF_GAIN_STEP_CYC
) (
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst_b,
   // Control port
   input  wire osf_pkg::reg_req_t      req,
   output logic                  [7:0] rdata_r,
   // Analog status, asynchronous to clock
   input  wire osf_pkg::power_status_t pwr_in,
   input  wire osf_pkg::event_status_t evt_in,
   // Right line output stage settings
   output osf_pkg::line_ctrl_t         line_ctrl
);
   import osf_pkg::*;

   // Parameter sanity
   generate
      if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_bad_step
         $error("STEP_CYC must lie between 1 and 65535");
      end
   endgenerate

   localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

   // Synchronised copies of the analog levels
   power_status_t pwr_s;          // Power status after two flops
   event_status_t evt_s;          // Event levels after two flops

   // Software controls
   logic [3:0]    level_r;        // Programmed boost code
   logic          unmute_r;       // One lets audio through

   // Gain ramp
   logic [3:0]    gain_now_r;     // Code actually applied to the stage
   logic [15:0]   step_cnt_r;     // Cycles since the last gain step
   logic          pending_r;      // Applied code still short of target

   // Headset edge detection
   logic          hs_prev_r;      // Last seen headset level
   logic          hs_primed_r;    // Blocks a false edge after reset
   logic          hs_evt;         // One-cycle insertion or removal

   // Sticky bank and its controls
   logic [7:0]    sticky_set;
   logic [7:0]    sticky_clr;
   logic [7:0]    sticky_r;
   logic [7:0]    live_flags;     // Unlatched view of the same events

   // Decoded accesses
   logic          wr_line;
   logic          wr_sticky;
   logic          rd_sticky;
   logic [7:0]    rd_mux;

   // Both status groups share one synchroniser bank
   level_sync #(
      .WIDTH    (15)
   ) u_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in ({pwr_in, evt_in}),
      .sync_out ({pwr_s, evt_s})
   );

   // Address decode
   assign wr_line   = req.wr && (req.addr == `OSF_ADDR_LINE_CTRL);
   assign wr_sticky = req.wr && (req.addr == `OSF_ADDR_STICKY);
   assign rd_sticky = req.rd && (req.addr == `OSF_ADDR_STICKY);

   // Level and mute controls; only these two fields take writes
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         level_r  <= `OSF_LEVEL_RST;
         unmute_r <= `OSF_MUTE_RST;
      end else if (wr_line) begin
         // Reserved and status bits of this byte are dropped
         level_r  <= req.wdata[`OSF_LEVEL_MSB:`OSF_LEVEL_LSB];
         unmute_r <= req.wdata[`OSF_MUTE_BIT];
      end
   end

   // Step timer; ramping avoids zipper noise from big gain jumps
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         step_cnt_r <= 16'h0000;
      end else if (step_cnt_r == STEP_LAST) begin
         step_cnt_r <= 16'h0000;
      end else begin
         step_cnt_r <= step_cnt_r + 16'h0001;
      end
   end

   // Applied gain walks toward the target one dB per step
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gain_now_r <= `OSF_LEVEL_RST;
      end else if (step_cnt_r == STEP_LAST) begin
         if (gain_now_r < level_r) begin
            gain_now_r <= gain_now_r + 4'h1;
         end else if (gain_now_r > level_r) begin
            gain_now_r <= gain_now_r - 4'h1;
         end
      end
   end

   // Pending flag; starts set until the first compare
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pending_r <= `OSF_PEND_RST;
      end else begin
         pending_r <= (gain_now_r != level_r);
      end
   end

   // Outputs to the line stage come straight from flops
   assign line_ctrl.gain   = gain_now_r;
   assign line_ctrl.unmute = unmute_r;

   // Headset change detection on the synchronised level
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hs_prev_r   <= 1'b0;
         hs_primed_r <= 1'b0;
      end else begin
         hs_prev_r   <= evt_s.headset;
         hs_primed_r <= 1'b1;
      end
   end

   // Either direction counts, but not the first sample after reset
   assign hs_evt = hs_primed_r && (hs_prev_r != evt_s.headset);

   // Current event view for the real-time read, built from the same terms as sticky set
   always_comb begin
      live_flags      = 8'h00;
      live_flags[7:4] = evt_s.shorted;
      live_flags[2]   = hs_evt;
      live_flags[1]   = evt_s.gate_l;
      live_flags[0]   = evt_s.gate_r;
   end

   // Sticky set and clear terms
   always_comb begin
      sticky_set      = 8'h00;
      sticky_set[7:4] = evt_s.shorted;
      sticky_set[2]   = hs_evt;
      sticky_set[1]   = evt_s.gate_l;
      sticky_set[0]   = evt_s.gate_r;
      // A read clears everything it has just returned
      sticky_clr      = rd_sticky ? 8'hFF : 8'h00;
      // The writable bit may also be cleared by writing zero
      if (wr_sticky && !req.wdata[`OSF_GATE_R_BIT]) begin
         sticky_clr[`OSF_GATE_R_BIT] = 1'b1;
      end
   end

   // Flags latch; a new event in a clearing cycle survives
   sticky_latch #(
      .WIDTH  (8)
   ) u_sticky (
      .clock  (clock),
      .rst_b  (rst_b),
      .set_in (sticky_set),
      .clr_in (sticky_clr),
      .flag_r (sticky_r)
   );

   // Read data selection; reserved bits read zero
   always_comb begin
      rd_mux = `OSF_UNMAPPED_DATA;
      unique case (req.addr)
         `OSF_ADDR_LINE_CTRL: begin
            rd_mux[`OSF_LEVEL_MSB:`OSF_LEVEL_LSB] = level_r;
            rd_mux[`OSF_MUTE_BIT] = unmute_r;
            rd_mux[`OSF_PEND_BIT] = pending_r;
            rd_mux[`OSF_LPWR_BIT] = pwr_s.line_r;
         end
         `OSF_ADDR_PWR_STAT: begin
            rd_mux[7] = pwr_s.dac_l;
            rd_mux[6] = pwr_s.dac_r;
            rd_mux[4] = pwr_s.line_l;
            rd_mux[3] = pwr_s.line_r;
            rd_mux[2] = pwr_s.hp_l;
            rd_mux[1] = pwr_s.hp_r;
         end
         `OSF_ADDR_SHORT_STAT: begin
            rd_mux[7:4] = evt_s.shorted;
            rd_mux[3]   = pwr_s.com_l;
            rd_mux[2]   = pwr_s.com_r;
         end
         `OSF_ADDR_STICKY: begin
            rd_mux = sticky_r;
         end
         `OSF_ADDR_REALTIME: begin
            rd_mux = live_flags;
         end
         default: begin
            rd_mux = `OSF_UNMAPPED_DATA;
         end
      endcase
   end

   // Read data register; holds until the next read
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else if (req.rd) begin
         rdata_r <= rd_mux;
      end
   end

endmodule

// file: hdl/sticky_latch.sv
`timescale 1ns/1ps
// Bank of sticky flags; a new event always beats a clear
module sticky_latch #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Event and clear controls
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clr_in,
   // Latched flags
   output logic      [WIDTH-1:0] flag_r
);

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("sticky_latch width must be at least one");
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         // Set over clear so no event is lost on a clearing read
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               flag_r[i] <= 1'b0;
            end else if (set_in[i]) begin
               flag_r[i] <= 1'b1;
            end else if (clr_in[i]) begin
               flag_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule
